/* src/scue_pkg.sv */
// Package: register map, field layout, reset values, commands and states of the UART channel engine
package scue_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_MODE = 8'h00;
	localparam logic [7:0] IDX_CMD = 8'h01;
	localparam logic [7:0] IDX_TX_PTR = 8'h02;
	localparam logic [7:0] IDX_RX_PTR = 8'h03;
	localparam logic [7:0] IDX_EVENT = 8'h04;
	localparam logic [7:0] IDX_RX_MAX = 8'h05;
	localparam logic [7:0] IDX_IDLE_LIMIT = 8'h28;
	localparam logic [7:0] IDX_IDLE_COUNT = 8'h2a;
	localparam logic [7:0] IDX_BRK_LEN = 8'h2c;
	localparam logic [7:0] IDX_BRK_CNT = 8'h2e;
	localparam logic [7:0] IDX_BRK_REP = 8'h30;
	localparam logic [7:0] IDX_TEMP_MASK = 8'h32;
	localparam logic [7:0] IDX_TX_DESC = 8'h40;
	localparam logic [7:0] IDX_RX_DESC = 8'h50;

	////////////////////////////////////////////////////////////////////////////////
	// Channel mode register fields
	localparam int MODE_TX_EN = 0;
	localparam int MODE_RX_EN = 1;
	localparam int MODE_LEN_LSB = 2;
	localparam int MODE_PAR_EN = 6;
	localparam int MODE_PAR_ODD = 7;
	localparam int MODE_TWO_STOP = 8;
	localparam int MODE_DIV_LSB = 16;
	localparam logic [31:0] MODE_RESET = 32'h0010_0020;
	localparam logic [5:0] RX_MAX_RESET = 6'h10;

	// Descriptor word fields
	localparam int DESC_FLAG = 16;
	localparam int DESC_WRAP = 17;
	localparam int DESC_CM = 18;
	localparam int DESC_IRQ = 19;
	localparam int DESC_IDLE = 20;
	localparam int DESC_PERR = 21;
	localparam int DESC_FERR = 22;
	localparam int DESC_CNT_LSB = 24;

	// Event register bits
	localparam int EV_TX_DONE = 0;
	localparam int EV_RX_CLOSE = 1;
	localparam int EV_IDLE = 2;
	localparam int EV_BREAK = 3;

	////////////////////////////////////////////////////////////////////////////////
	// Commands written to the command register
	typedef enum logic [2:0] {
		CMD_NONE = 3'b000,
		CMD_HALT_TX = 3'b001,
		CMD_RESUME_TX = 3'b010,
		CMD_RESET_TX = 3'b011,
		CMD_CLOSE_RX = 3'b100,
		CMD_RESET_RX = 3'b101,
		CMD_RESET_BOTH = 3'b110
	} scue_cmd_t;

	typedef enum logic [2:0] {
		TXS_RUN = 3'b000,
		TXS_DRAIN = 3'b001,
		TXS_BREAK = 3'b010,
		TXS_GUARD = 3'b011,
		TXS_HALTED = 3'b100
	} scue_tx_t;

	typedef enum logic [1:0] {
		RXS_HUNT = 2'b00,
		RXS_START = 2'b01,
		RXS_BITS = 2'b10,
		RXS_BREAK = 2'b11
	} scue_rx_t;

	// Decoded channel mode
	typedef struct packed {
		logic tx_en;
		logic rx_en;
		logic [3:0] len;
		logic par_en;
		logic par_odd;
		logic two_stop;
		logic [7:0] div;
	} scue_mode_t;

endpackage : scue_pkg

/* src/scue_uart.sv */
// UART channel engine: APB registers, descriptor tables, transmitter and receiver
//
// What this block does
// - Clearing transmit enable disables the transmitter and halts it until a resume or transmit reset command.
// - Once enabled, sending starts at the pointed descriptor when it is ready.
// - Disable, reset transmit parameters, adjust, enable again: quick transmitter restart.
// - Clearing receive enable aborts reception at once and resets the receiver.
// - Once enabled, reception fills the pointed descriptor if it is marked empty.
// - Disable, reset receive parameters, adjust, enable again: quick receiver restart.
// - Protocol change: clear both enables, reset both, rewrite mode, enable both.
// - Data length 5 to 14, one or two stops, even, odd or no parity.
// - One shared bit rate; no modem lines and no fractional stop bits.
// - After data, idle characters are counted; reaching the limit closes the buffer.
// - An idle limit of zero never closes a buffer on idle time.
// - Idle character is start, data, optional parity and stop bits long.
// - Length of the last break is kept in bit times.
// - Break counter rises once per break, however long it lasts.
// - Each halt sends the programmed number of all-zero break characters.
// - Enabled transmitter sends idles and polls at once, then every character time.
// - When data leaves a descriptor, its ready bit clears, event if flagged.
// - A ready next descriptor follows without a gap; otherwise idles are sent.
// - Continuous-mode descriptors keep ready set and are resent on the next pass.
// - Halt aborts the message, drains up to two characters, pointer stays.
// - Close-receive closes the descriptor in use and moves on; no-op when idle.
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none

module scue_uart
	import scue_pkg::*;
#(
	parameter int DESC_N = 4
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Serial line
	input wire logic rxd,
	output logic txd
);

	import scue_pkg::*;

	localparam int PW = (DESC_N > 1) ? $clog2(DESC_N) : 1;

	////////////////////////////////////////////////////////////////////////////////
	// Storage
	logic [31:0] mode_reg;
	logic [31:0] tx_tab [DESC_N];
	logic [31:0] rx_tab [DESC_N];
	logic [PW-1:0] tx_ptr;
	logic [PW-1:0] rx_ptr;
	logic [3:0] events;
	logic [5:0] rx_max;
	logic [15:0] idle_timeout_limit;
	logic [15:0] idle_countdown;
	logic [15:0] last_break_length;
	logic [15:0] break_event_count;
	logic [15:0] tx_break_repeat;
	scue_mode_t m;

	// Mode decode with data length held to the legal span
	always_comb begin
		m.tx_en = mode_reg[MODE_TX_EN];
		m.rx_en = mode_reg[MODE_RX_EN];
		m.len = mode_reg[MODE_LEN_LSB +: 4];
		if (m.len < 4'h5) m.len = 4'h5;
		if (m.len > 4'he) m.len = 4'he;
		m.par_en = mode_reg[MODE_PAR_EN];
		m.par_odd = mode_reg[MODE_PAR_ODD];
		m.two_stop = mode_reg[MODE_TWO_STOP];
		m.div = (mode_reg[MODE_DIV_LSB +: 8] == 8'h00) ? 8'h01 : mode_reg[MODE_DIV_LSB +: 8];
	end

	// Bit times of one character, also the idle character length
	logic [4:0] char_bits;
	logic [4:0] rx_bits;
	assign char_bits = 5'h01 + {1'b0, m.len} + {4'h0, m.par_en} + 5'h01 + {4'h0, m.two_stop};
	assign rx_bits = {1'b0, m.len} + {4'h0, m.par_en} + 5'h01;

	// Character frame, unused upper bits are stop ones
	function automatic logic [17:0] scue_frame(input logic [13:0] d, input logic [3:0] len,
			input logic par_en, input logic par_odd);
		logic [17:0] f;
		logic p;
		f = '1;
		f[0] = 1'b0;
		p = par_odd;
		for (int i = 0; i < 14; i++) begin
			if (i < int'(len)) begin
				f[i + 1] = d[i];
				p = p ^ d[i];
			end
		end
		if (par_en) f[len + 4'h1] = p;
		return f;
	endfunction : scue_frame

	////////////////////////////////////////////////////////////////////////////////
	// APB decode
	logic setup;
	logic wr;
	logic [7:0] idx;
	logic addr_ok;
	logic [31:0] rd_data;
	logic rd_ok;
	scue_cmd_t cmd;
	assign setup = psel & ~penable;
	assign wr = psel & penable & pready & pwrite & addr_ok; // Refused places take no write
	assign idx = paddr[9:2];
	assign addr_ok = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
	assign cmd = (wr && idx == IDX_CMD) ? scue_cmd_t'(pwdata[2:0]) : CMD_NONE;

	// Read mux; the temporary mask reads as zero
	always_comb begin
		rd_data = 32'h0000_0000;
		rd_ok = addr_ok;
		if (idx >= IDX_TX_DESC && idx < IDX_TX_DESC + 8'(DESC_N)) begin
			rd_data = tx_tab[PW'(idx - IDX_TX_DESC)];
		end else if (idx >= IDX_RX_DESC && idx < IDX_RX_DESC + 8'(DESC_N)) begin
			rd_data = rx_tab[PW'(idx - IDX_RX_DESC)];
		end else begin
			case (idx)
				IDX_MODE: rd_data = mode_reg;
				IDX_CMD: rd_data = 32'h0000_0000;
				IDX_TX_PTR: rd_data = 32'(tx_ptr);
				IDX_RX_PTR: rd_data = 32'(rx_ptr);
				IDX_EVENT: rd_data = {28'h000_0000, events};
				IDX_RX_MAX: rd_data = {26'h000_0000, rx_max};
				IDX_IDLE_LIMIT: rd_data = {16'h0000, idle_timeout_limit};
				IDX_IDLE_COUNT: rd_data = {16'h0000, idle_countdown};
				IDX_BRK_LEN: rd_data = {16'h0000, last_break_length};
				IDX_BRK_CNT: rd_data = {16'h0000, break_event_count};
				IDX_BRK_REP: rd_data = {16'h0000, tx_break_repeat};
				IDX_TEMP_MASK: rd_data = 32'h0000_0000;
				default: rd_ok = 1'b0;
			endcase
		end
	end

	// No wait state: answer is prepared in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready <= setup;
			pslverr <= setup & ~rd_ok; // Error stands with pready only
			if (setup) begin
				prdata <= (!pwrite && rd_ok) ? rd_data : 32'h0000_0000;
			end
		end
	end

	// Plain software registers; parameter resets clear the break repeat and idle limit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_reg <= MODE_RESET;
			rx_max <= RX_MAX_RESET;
			idle_timeout_limit <= 16'h0000;
			tx_break_repeat <= 16'h0000;
		end else begin
			if (wr && idx == IDX_MODE) mode_reg <= pwdata;
			if (wr && idx == IDX_RX_MAX) rx_max <= pwdata[5:0];
			if (wr && idx == IDX_IDLE_LIMIT) idle_timeout_limit <= pwdata[15:0];
			if (wr && idx == IDX_BRK_REP) tx_break_repeat <= pwdata[15:0];
			if (cmd == CMD_RESET_TX || cmd == CMD_RESET_BOTH) tx_break_repeat <= 16'h0000;
			if (cmd == CMD_RESET_RX || cmd == CMD_RESET_BOTH) idle_timeout_limit <= 16'h0000;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Transmitter
	scue_tx_t tx_state;
	logic tx_en_q;
	logic [7:0] tx_div;
	logic tx_tick;
	logic [17:0] tx_shift;
	logic [4:0] tx_left;
	logic [13:0] tx_hold;
	logic tx_hold_v;
	logic [4:0] poll_cnt;
	logic [15:0] brk_left;
	logic resume_pend;
	logic poll;
	logic fetch;
	logic finishing;
	assign tx_tick = (tx_div == 8'h00);
	assign finishing = tx_tick && tx_left <= 5'h01;
	// While a character is on the line, poll every cycle so a ready buffer lands gap-free
	assign poll = m.tx_en && tx_state == TXS_RUN && !tx_hold_v && (poll_cnt == 5'h00 || tx_left != 5'h00);
	assign fetch = poll && tx_tab[tx_ptr][DESC_FLAG];

	// Transmit bit clock; the receiver has its own phase counter at the same rate
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) tx_div <= 8'h00;
		else if (!m.tx_en || tx_tick) tx_div <= m.div - 8'h01;
		else tx_div <= tx_div - 8'h01;
	end

	// Poll interval of one character time
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) poll_cnt <= 5'h00;
		else if (!m.tx_en) poll_cnt <= 5'h00;
		else if (poll && !fetch && poll_cnt == 5'h00) poll_cnt <= char_bits;
		else if (tx_tick && poll_cnt != 5'h00) poll_cnt <= poll_cnt - 5'h01;
	end

	// Descriptor fetch into the holding stage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_hold <= 14'h0000;
			tx_hold_v <= 1'b0;
		end else if (!m.tx_en) begin
			tx_hold_v <= 1'b0;
		end else if (fetch) begin
			tx_hold <= tx_tab[tx_ptr][13:0];
			tx_hold_v <= 1'b1;
		end else if (finishing && tx_state != TXS_BREAK && tx_state != TXS_GUARD) begin
			tx_hold_v <= 1'b0;
		end
	end

	// Pointer: advances on fetch only, so a halt leaves it in place
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) tx_ptr <= '0;
		else if (cmd == CMD_RESET_TX || cmd == CMD_RESET_BOTH) tx_ptr <= '0;
		else if (wr && idx == IDX_TX_PTR) tx_ptr <= pwdata[PW-1:0];
		else if (fetch) tx_ptr <= (tx_tab[tx_ptr][DESC_WRAP] || tx_ptr == PW'(DESC_N - 1)) ? '0 : tx_ptr + 1'b1;
	end

	// Sequencing of data, drain, breaks and the guard idle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_state <= TXS_RUN;
			tx_en_q <= 1'b0;
			brk_left <= 16'h0000;
			resume_pend <= 1'b0;
		end else begin
			tx_en_q <= m.tx_en;
			if (cmd == CMD_RESET_TX || cmd == CMD_RESET_BOTH) begin
				tx_state <= TXS_RUN;
				resume_pend <= 1'b0;
			end else if (tx_en_q && !m.tx_en) begin
				tx_state <= TXS_HALTED;
				resume_pend <= 1'b0;
			end else if (cmd == CMD_HALT_TX && (tx_state == TXS_RUN || tx_state == TXS_HALTED)) begin
				tx_state <= TXS_DRAIN;
				brk_left <= tx_break_repeat;
				resume_pend <= 1'b0;
			end else if (cmd == CMD_RESUME_TX) begin
				if (tx_state == TXS_HALTED) tx_state <= TXS_RUN;
				else if (tx_state != TXS_RUN) resume_pend <= 1'b1;
			end else if (m.tx_en && finishing) begin
				case (tx_state)
					TXS_DRAIN: begin
						if (!tx_hold_v) tx_state <= (brk_left != 16'h0000) ? TXS_BREAK : TXS_GUARD;
						if (!tx_hold_v && brk_left != 16'h0000) brk_left <= brk_left - 16'h0001;
					end
					TXS_BREAK: begin
						if (brk_left != 16'h0000) brk_left <= brk_left - 16'h0001;
						else tx_state <= TXS_GUARD;
					end
					TXS_GUARD: tx_state <= resume_pend ? TXS_RUN : TXS_HALTED;
					default: tx_state <= tx_state;
				endcase
			end
		end
	end

	// Serialiser; breaks are a full character of zeros, guard is a character of ones
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_shift <= '1;
			tx_left <= 5'h00;
			txd <= 1'b1;
		end else if (!m.tx_en) begin
			tx_left <= 5'h00;
			txd <= 1'b1;
		end else if (tx_tick && tx_left > 5'h01) begin
			tx_shift <= {1'b1, tx_shift[17:1]};
			tx_left <= tx_left - 5'h01;
			txd <= tx_shift[1];
		end else if (finishing) begin
			if (tx_hold_v && (tx_state == TXS_RUN || tx_state == TXS_DRAIN)) begin
				tx_shift <= scue_frame(tx_hold, m.len, m.par_en, m.par_odd);
				tx_left <= char_bits;
				txd <= 1'b0;
			end else if ((tx_state == TXS_DRAIN && brk_left != 16'h0000) ||
					(tx_state == TXS_BREAK && brk_left != 16'h0000)) begin
				tx_shift <= '0;
				tx_left <= char_bits;
				txd <= 1'b0;
			end else if (tx_state == TXS_DRAIN || tx_state == TXS_BREAK) begin
				tx_shift <= '1;
				tx_left <= char_bits;
				txd <= 1'b1;
			end else begin
				tx_left <= 5'h00;
				txd <= 1'b1;
			end
		end
	end

	// Transmit table: software writes, engine clears ready after taking the data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < DESC_N; i++) tx_tab[i] <= 32'h0000_0000;
		end else begin
			for (int i = 0; i < DESC_N; i++) begin
				if (wr && idx == IDX_TX_DESC + 8'(i)) tx_tab[i] <= pwdata;
			end
			if (fetch && !tx_tab[tx_ptr][DESC_CM]) tx_tab[tx_ptr][DESC_FLAG] <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Receiver
	scue_rx_t rx_state;
	logic [7:0] rx_ph;
	logic rx_tick;
	logic [17:0] rx_sh;
	logic [4:0] rx_cnt;
	logic rx_zero;
	logic [4:0] idle_bits;
	logic idle_armed;
	logic [15:0] brk_bits;
	logic char_done;
	logic [17:0] rx_al;
	logic [13:0] rx_data;
	logic rx_perr;
	logic store;
	logic [5:0] cur_cnt;
	logic idle_close;
	logic close;
	logic rx_reset;
	assign rx_tick = (rx_ph == 8'h00);
	assign rx_reset = cmd == CMD_RESET_RX || cmd == CMD_RESET_BOTH;
	assign char_done = m.rx_en && rx_state == RXS_BITS && rx_tick && rx_cnt == rx_bits - 5'h01;
	assign rx_al = {rxd, rx_sh[17:1]} >> (5'd18 - rx_bits);
	assign rx_data = rx_al[13:0] & 14'((18'h00001 << m.len) - 18'h00001);
	assign rx_perr = m.par_en && ((^rx_data) ^ rx_al[m.len] ^ m.par_odd);
	assign cur_cnt = rx_tab[rx_ptr][DESC_CNT_LSB +: 6];
	assign store = char_done && !(rx_zero && !rxd) && rx_tab[rx_ptr][DESC_FLAG];
	assign idle_close = m.rx_en && rx_state == RXS_HUNT && rx_tick && rxd && idle_armed &&
		idle_bits == char_bits - 5'h01 && idle_countdown == 16'h0001;
	assign close = (store && cur_cnt + 6'h01 >= rx_max) ||
		(cur_cnt != 6'h00 && rx_tab[rx_ptr][DESC_FLAG] &&
		(idle_close || cmd == CMD_CLOSE_RX));

	// Receive bit framing, break tracking and idle counting
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_state <= RXS_HUNT;
			rx_ph <= 8'h00;
			rx_sh <= 18'h00000;
			rx_cnt <= 5'h00;
			rx_zero <= 1'b0;
			idle_bits <= 5'h00;
			brk_bits <= 16'h0000;
		end else if (!m.rx_en) begin
			rx_state <= RXS_HUNT;
			rx_ph <= 8'h00;
			idle_bits <= 5'h00;
		end else begin
			rx_ph <= rx_tick ? m.div - 8'h01 : rx_ph - 8'h01;
			case (rx_state)
				RXS_HUNT: begin
					if (!rxd) begin
						rx_state <= RXS_START;
						rx_ph <= {1'b0, m.div[7:1]};
						idle_bits <= 5'h00;
					end else if (rx_tick) begin
						idle_bits <= (idle_bits == char_bits - 5'h01) ? 5'h00 : idle_bits + 5'h01;
					end
				end
				RXS_START: if (rx_tick) begin
					rx_state <= rxd ? RXS_HUNT : RXS_BITS;
					rx_cnt <= 5'h00;
					rx_zero <= 1'b1;
				end
				RXS_BITS: if (rx_tick) begin
					rx_sh <= {rxd, rx_sh[17:1]};
					rx_zero <= rx_zero & ~rxd;
					rx_cnt <= rx_cnt + 5'h01;
					if (char_done) begin
						rx_state <= (rx_zero && !rxd) ? RXS_BREAK : RXS_HUNT;
						brk_bits <= {11'h000, rx_bits} + 16'h0001;
					end
				end
				RXS_BREAK: if (rx_tick) begin
					if (!rxd) brk_bits <= brk_bits + 16'h0001;
					else rx_state <= RXS_HUNT;
				end
				default: rx_state <= RXS_HUNT;
			endcase
		end
	end

	// Idle timeout countdown, armed by each data character
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idle_countdown <= 16'h0000;
			idle_armed <= 1'b0;
		end else if (rx_reset || !m.rx_en) begin
			idle_countdown <= 16'h0000;
			idle_armed <= 1'b0;
		end else if (char_done && !(rx_zero && !rxd)) begin
			idle_countdown <= idle_timeout_limit;
			idle_armed <= idle_timeout_limit != 16'h0000;
		end else if (m.rx_en && rx_state == RXS_HUNT && rx_tick && rxd && idle_armed &&
				idle_bits == char_bits - 5'h01) begin
			idle_countdown <= idle_countdown - 16'h0001;
			if (idle_countdown == 16'h0001) idle_armed <= 1'b0;
		end
	end

	// Break statistics
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_break_length <= 16'h0000;
			break_event_count <= 16'h0000;
		end else if (rx_reset) begin
			last_break_length <= 16'h0000;
			break_event_count <= 16'h0000;
		end else begin
			if (wr && idx == IDX_BRK_CNT) break_event_count <= pwdata[15:0];
			if (char_done && rx_zero && !rxd) break_event_count <= break_event_count + 16'h0001;
			if (m.rx_en && rx_state == RXS_BREAK && rx_tick && rxd) last_break_length <= brk_bits;
		end
	end

	// Receive pointer moves past each closed descriptor
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) rx_ptr <= '0;
		else if (rx_reset) rx_ptr <= '0;
		else if (wr && idx == IDX_RX_PTR) rx_ptr <= pwdata[PW-1:0];
		else if (close) rx_ptr <= (rx_tab[rx_ptr][DESC_WRAP] || rx_ptr == PW'(DESC_N - 1)) ? '0 : rx_ptr + 1'b1;
	end

	// Receive table: characters land in the current descriptor, close clears empty
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < DESC_N; i++) rx_tab[i] <= 32'h0000_0000;
		end else begin
			for (int i = 0; i < DESC_N; i++) begin
				if (wr && idx == IDX_RX_DESC + 8'(i)) rx_tab[i] <= pwdata;
			end
			if (store) begin
				rx_tab[rx_ptr][13:0] <= rx_data;
				rx_tab[rx_ptr][DESC_CNT_LSB +: 6] <= cur_cnt + 6'h01;
				rx_tab[rx_ptr][DESC_PERR] <= rx_tab[rx_ptr][DESC_PERR] | rx_perr;
				rx_tab[rx_ptr][DESC_FERR] <= rx_tab[rx_ptr][DESC_FERR] | ~rxd;
			end
			if (close) begin
				if (!rx_tab[rx_ptr][DESC_CM]) rx_tab[rx_ptr][DESC_FLAG] <= 1'b0;
				rx_tab[rx_ptr][DESC_IDLE] <= idle_close;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sticky events, write one to clear; a new event wins over the clear
	logic [3:0] ev_set;
	assign ev_set[EV_TX_DONE] = fetch && tx_tab[tx_ptr][DESC_IRQ];
	assign ev_set[EV_RX_CLOSE] = close;
	assign ev_set[EV_IDLE] = idle_close;
	assign ev_set[EV_BREAK] = char_done && rx_zero && !rxd;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) events <= 4'h0;
		else if (wr && idx == IDX_EVENT) events <= (events & ~pwdata[3:0]) | ev_set;
		else events <= events | ev_set;
	end

endmodule : scue_uart

`default_nettype wire

/* tb/scue_uart_props.sv */
// Checker: APB handshake and serial line framing of the UART channel engine
`timescale 1ns/1ps
`default_nettype none

module scue_uart_props #(
	parameter int DESC_N = 4
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Serial line
	input wire logic rxd,
	input wire logic txd
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// Completed access, sampled at the edge that ends it
	logic acc;
	assign acc = psel && penable && pready;

	////////////////////////////////////////////////////////////////////////////////
	// Register bus: one wait-free access cycle, errors read as zero
	a_ready_after_setup: assert property (psel && !penable |=> pready)
		else $error("pready missing after setup");
	a_ready_single: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_err_reads_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
		else $error("refused read returned data");
	a_unaligned_err: assert property (acc && paddr[1:0] != 2'b00 |-> pslverr)
		else $error("unaligned access not refused");
	a_mask_reads_zero: assert property (acc && !pwrite && paddr == 12'h0c8 |-> prdata == 32'h0)
		else $error("reserved word not zero");

	////////////////////////////////////////////////////////////////////////////////
	// Line: bits last a full bit time; 8 covers any divider from 9 up
	a_start_low: assert property ($fell(txd) |=> !txd [*8])
		else $error("start bit too short");
	a_bit_hold: assert property ($changed(txd) |=> $stable(txd) [*8])
		else $error("line bit too short");

	c_refused: cover property (pslverr);
	c_frame: cover property ($fell(txd));
	c_write: cover property (acc && pwrite);
endmodule : scue_uart_props

bind scue_uart scue_uart_props #(.DESC_N(DESC_N)) i_scue_uart_props (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.rxd(rxd), .txd(txd)
);
`default_nettype wire

/* tb/scue_remote.sv */
// Remote serial device: 8N1 sender on rxd, frame sampler on txd
`timescale 1ns/1ps
`default_nettype none

module scue_remote #(
	parameter int BIT = 16
) (
	// Clock
	input wire logic pclk,
	// Serial line
	input wire logic txd,
	output logic rxd
);
	logic [7:0] got;
	logic got_stop;
	int frames;

	initial begin
		rxd = 1'b1;
		frames = 0;
	end

	// Hold the line at a level for whole bit times, same rate both ways
	task automatic hold(input logic v, input int bits);
		rxd <= v;
		repeat (bits * BIT) @(posedge pclk);
	endtask : hold

	task automatic send(input logic [7:0] d);
		hold(1'b0, 1);
		for (int i = 0; i < 8; i++) begin
			hold(d[i], 1);
		end
		hold(1'b1, 1);
	endtask : send

	// Sample mid-bit; a break shows as zero data with a low stop bit
	always begin
		@(negedge txd);
		repeat (BIT / 2) @(posedge pclk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT) @(posedge pclk);
			got[i] = txd;
		end
		repeat (BIT) @(posedge pclk);
		got_stop = txd;
		frames++;
		wait (txd === 1'b1);
	end
endmodule : scue_remote
`default_nettype wire

/* tb/scue_uart_tb_top.sv */
// Testbench: register, transmit, receive and break tests of the UART channel engine
`timescale 1ns/1ps
`default_nettype none

module scue_uart_tb_top;
	import scue_pkg::*;

	logic pclk = 1'b0;
	logic presetn, psel, penable, pwrite, pready, pslverr, rxd, txd, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	int error_cnt = 0;
	int compares = 0;
	logic [7:0] zl [5] = '{IDX_TX_PTR, IDX_RX_PTR, IDX_BRK_CNT, IDX_BRK_LEN, IDX_BRK_REP};

	scue_uart #(.DESC_N(4)) i_scue_uart (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd));
	scue_remote #(.BIT(16)) i_scue_remote (.pclk(pclk), .txd(txd), .rxd(rxd));

	// 10 MHz clock
	always #50 pclk = ~pclk;

	task automatic report_and_stop();
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// One APB transfer; request held until pready is sampled high
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk(32'(pready), 32'h1);
		if (pready !== 1'b1) report_and_stop();
		@(posedge pclk);
	endtask : xfer

	task automatic rd(input logic [7:0] i);
		xfer(1'b0, {2'b00, i, 2'b00}, 32'h0);
	endtask : rd

	task automatic wr(input logic [7:0] i, input logic [31:0] d);
		xfer(1'b1, {2'b00, i, 2'b00}, d);
	endtask : wr

	// Bounded polls of a register field and of frames seen on the line
	task automatic poll(input logic [7:0] i, input logic [31:0] m, input logic [31:0] x);
		int k;
		for (k = 0; k < 300; k++) begin
			rd(i);
			if ((q & m) === x) break;
		end
		chk(q & m, x);
		if (k >= 300) report_and_stop();
	endtask : poll

	task automatic wait_tx(input int n);
		int k;
		for (k = 0; k < 4000 && i_scue_remote.frames < n; k++) @(posedge pclk);
		chk(32'(i_scue_remote.frames), 32'(n));
		if (k >= 4000) report_and_stop();
	endtask : wait_tx

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		// Reset values, reserved word and refused places
		rd(IDX_MODE);
		chk(q, MODE_RESET);
		for (int k = 0; k < 6; k++) begin
			rd(IDX_IDLE_LIMIT + 8'(2 * k));
			chk(q, 32'h0);
		end
		xfer(1'b0, 12'h3f0, 32'h0);
		chk(32'(e), 32'h1);
		xfer(1'b1, 12'h0a2, 32'h1);
		chk(32'(e), 32'h1);
		rd(IDX_IDLE_LIMIT);
		chk(q, 32'h0);
		$display("test registers done");
		// Two ready descriptors back to back, then a continuous one
		wr(IDX_TX_DESC, 32'h0001_00a5);
		wr(IDX_TX_DESC + 8'h1, 32'h0001_003c);
		wr(IDX_TX_DESC + 8'h2, 32'h0005_0011);
		wr(IDX_MODE, MODE_RESET | 32'h1);
		wait_tx(1);
		chk(32'(i_scue_remote.got), 32'ha5);
		rd(IDX_TX_DESC);
		chk(32'(q[16]), 32'h0);
		wait_tx(3);
		chk(32'(i_scue_remote.got), 32'h11);
		rd(IDX_TX_DESC + 8'h2);
		chk(32'(q[16]), 32'h1);
		// Halt sends one all-zero break character
		wr(IDX_BRK_REP, 32'h1);
		wr(IDX_CMD, 32'(CMD_HALT_TX));
		wait_tx(4);
		chk({23'h0, i_scue_remote.got_stop, i_scue_remote.got}, 32'h0);
		rd(IDX_TX_PTR);
		chk(q, 32'h3);
		$display("test transmit done");
		// Idle timeout closes, zero limit never does, close command does
		wr(IDX_RX_DESC, 32'h0001_0000);
		wr(IDX_RX_DESC + 8'h1, 32'h0001_0000);
		wr(IDX_IDLE_LIMIT, 32'h2);
		wr(IDX_MODE, MODE_RESET | 32'h2);
		i_scue_remote.send(8'h5a);
		poll(IDX_RX_DESC, 32'h0011_3fff, 32'h0010_005a);
		wr(IDX_IDLE_LIMIT, 32'h0);
		i_scue_remote.send(8'h77);
		i_scue_remote.hold(1'b1, 50);
		rd(IDX_RX_DESC + 8'h1);
		chk(q & 32'h0001_3fff, 32'h0001_0077);
		wr(IDX_CMD, 32'(CMD_CLOSE_RX));
		poll(IDX_RX_DESC + 8'h1, 32'h0001_0000, 32'h0);
		wr(IDX_CMD, 32'(CMD_CLOSE_RX));
		rd(IDX_RX_PTR);
		chk(q, 32'h2);
		// A 40-bit break counts once and is measured
		i_scue_remote.hold(1'b0, 40);
		i_scue_remote.hold(1'b1, 2);
		poll(IDX_BRK_CNT, 32'hffff, 32'h1);
		rd(IDX_BRK_LEN);
		chk(32'(q >= 30 && q <= 50), 32'h1);
		$display("test receive done");
		// Protocol switch: both off, reset both, enable both
		wr(IDX_MODE, MODE_RESET);
		wr(IDX_CMD, 32'(CMD_RESET_BOTH));
		foreach (zl[k]) begin
			rd(zl[k]);
			chk(q, 32'h0);
		end
		wr(IDX_MODE, MODE_RESET | 32'h3);
		rd(IDX_MODE);
		chk(q, MODE_RESET | 32'h3);
		$display("test switch done");
		report_and_stop();
	end
endmodule : scue_uart_tb_top
`default_nettype wire
